// ### emp_pkg.sv
// shared constants for the external memory pin interface
`default_nettype none
package emp_pkg;

  localparam int ADDR_LOW_W = 15;
  localparam int ADDR_MUX_W = 11;
  localparam int ADDR_FULL_W = 2 * ADDR_MUX_W;
  localparam int DATA_W = 8;
  localparam int NARROW_W = 4;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 4;

  localparam int BIT_FIFTEEN = 15;
  localparam int BIT_SIXTEEN = 16;
  localparam int BIT_SEVENTEEN = 17;

  localparam logic [1:0] SEL_ZERO = 2'h0;
  localparam logic [1:0] SEL_ONE = 2'h1;
  localparam logic [1:0] SEL_TWO = 2'h2;
  localparam logic [1:0] SEL_THREE = 2'h3;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_ROW_NS = 15;
  localparam int T_STROBE_NS = 10;
  localparam int ROW_CYC = (T_ROW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic PIN_HIGH = 1'b1;
  localparam logic PIN_LOW = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ROW,
    ST_ACC,
    ST_END
  } emp_state_e;

endpackage
`default_nettype wire

// ### emp_sync.sv
// two-stage synchroniser for the data pins
`timescale 1ns/1ps
`default_nettype none
module emp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // first stage feeds only the second
  always_comb begin
    meta_nxt = d_in;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;

endmodule
`default_nettype wire

// ### emp_pins.sv
// external memory pin sequencer: address, selects, strobes, data bus
//
// Summary of operation
// - dynamic: row then column on low eleven
// - static: address bits 0-14 driven directly
// - bit fifteen pin as plain address
// - bit fifteen pin as static select three
// - bit sixteen pin: address or select two
// - bit sixteen pin is column strobe dynamically
// - bit seventeen pin: address or select one
// - bit seventeen pin is row strobe dynamically
// - dedicated pin gives static select zero
// - write strobe low only during writes
// - read strobe low only during reads
// - data sampled on reads, driven on writes
// - data bus undriven when idle
// - four-bit mode: upper lines never driven
// - hardware reset: pins high, data floating
`timescale 1ns/1ps
`default_nettype none
module emp_pins
  import emp_pkg::*;
#(
  parameter int ROW_CYCLES = ROW_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic SW_RESET_IN,
  input wire logic IND_RESET_IN,
  input wire logic STOP_IN,
  input wire logic DYNAMIC_MODE_IN,
  input wire logic REFRESH_EN_IN,
  input wire logic NARROW_BUS_IN,
  input wire logic SELECT_THREE_EN_IN,
  input wire logic SELECT_TWO_EN_IN,
  input wire logic SELECT_ONE_EN_IN,
  input wire logic ACC_REQ_IN,
  input wire logic ACC_WRITE_IN,
  input wire logic [1:0] ACC_SELECT_IN,
  input wire logic [ADDR_FULL_W-1:0] ACC_ADDR_IN,
  input wire logic [DATA_W-1:0] ACC_WDATA_IN,
  output logic ACC_READY_OUT,
  output logic ACC_DONE_OUT,
  output logic [DATA_W-1:0] ACC_RDATA_OUT,
  output logic [ADDR_LOW_W-1:0] LOW_ADDRESS_LINES_OUT,
  output logic ADDRESS_BIT_FIFTEEN_OUT,
  output logic ADDRESS_BIT_SIXTEEN_OUT,
  output logic ADDRESS_BIT_SEVENTEEN_OUT,
  output logic STATIC_SELECT_ZERO_N_OUT,
  output logic WRITE_STROBE_N_OUT,
  output logic READ_STROBE_N_OUT,
  input wire logic [DATA_W-1:0] MEMORY_DATA_BUS_IN,
  output logic [DATA_W-1:0] MEMORY_DATA_BUS_OUT,
  output logic [DATA_W-1:0] MEMORY_DATA_BUS_OE_OUT
);

  // counts must fit the shared down-counter
  if (ROW_CYCLES < 1 || ROW_CYCLES >= (1 << CNT_W)) begin : g_bad_row
    $error("ROW_CYCLES out of range");
  end
  if (STROBE_CYCLES < 1 || STROBE_CYCLES + SYNC_STAGES >= (1 << CNT_W)) begin : g_bad_strobe
    $error("STROBE_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] ROW_LAST = CNT_W'(ROW_CYCLES - 1);
  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(STROBE_CYCLES - 1);
  // reads hold the strobe longer so synchronised data is settled at capture
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(STROBE_CYCLES + SYNC_STAGES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // data pin synchroniser

  logic [DATA_W-1:0] data_sync;

  emp_sync #(
    .WIDTH(DATA_W)
  ) u_sync (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(MEMORY_DATA_BUS_IN),
    .q_out(data_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // lane enable mask

  logic [DATA_W-1:0] lane_ok;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_lane
      assign lane_ok[gi] = !NARROW_BUS_IN || (gi < NARROW_W);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // sequencer state

  emp_state_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [ADDR_FULL_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic write_r, write_nxt;
  logic dyn_r, dyn_nxt;

  logic [ADDR_LOW_W-1:0] low_r, low_nxt;
  logic pin15_r, pin15_nxt;
  logic pin16_r, pin16_nxt;
  logic pin17_r, pin17_nxt;
  logic sel0_n_r, sel0_n_nxt;
  logic wr_n_r, wr_n_nxt;
  logic rd_n_r, rd_n_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic [DATA_W-1:0] doe_r, doe_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic ready_r, ready_nxt;

  logic in_reset;
  logic take;

  assign in_reset = SW_RESET_IN || IND_RESET_IN || STOP_IN;
  assign take = (st_r == ST_IDLE) && ready_r && ACC_REQ_IN;

  // level of a shared pin that is a select for static accesses
  function automatic logic sel_level(input logic [1:0] want, input logic [1:0] cur);
    sel_level = (want == cur) ? PIN_LOW : PIN_HIGH;
  endfunction

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    sel_nxt = sel_r;
    write_nxt = write_r;
    dyn_nxt = dyn_r;
    low_nxt = low_r;
    pin15_nxt = pin15_r;
    pin16_nxt = pin16_r;
    pin17_nxt = pin17_r;
    sel0_n_nxt = PIN_HIGH;
    wr_n_nxt = PIN_HIGH;
    rd_n_nxt = PIN_HIGH;
    dout_nxt = dout_r;
    doe_nxt = '0;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;

    case (st_r)
      ST_IDLE: begin
        if (take) begin
          addr_nxt = ACC_ADDR_IN;
          wdata_nxt = ACC_WDATA_IN;
          sel_nxt = ACC_SELECT_IN;
          write_nxt = ACC_WRITE_IN;
          dyn_nxt = DYNAMIC_MODE_IN;
          if (DYNAMIC_MODE_IN) begin
            low_nxt[ADDR_MUX_W-1:0] = ACC_ADDR_IN[ADDR_FULL_W-1:ADDR_MUX_W];
            pin17_nxt = PIN_LOW;
            pin16_nxt = PIN_HIGH;
            cnt_nxt = ROW_LAST;
            st_nxt = ST_ROW;
          end else begin
            low_nxt = ACC_ADDR_IN[ADDR_LOW_W-1:0];
            pin15_nxt = SELECT_THREE_EN_IN ? sel_level(SEL_THREE, ACC_SELECT_IN) : ACC_ADDR_IN[BIT_FIFTEEN];
            pin16_nxt = SELECT_TWO_EN_IN ? sel_level(SEL_TWO, ACC_SELECT_IN) : ACC_ADDR_IN[BIT_SIXTEEN];
            pin17_nxt = SELECT_ONE_EN_IN ? sel_level(SEL_ONE, ACC_SELECT_IN) : ACC_ADDR_IN[BIT_SEVENTEEN];
            sel0_n_nxt = sel_level(SEL_ZERO, ACC_SELECT_IN);
            wr_n_nxt = !ACC_WRITE_IN;
            rd_n_nxt = ACC_WRITE_IN;
            dout_nxt = ACC_WDATA_IN;
            doe_nxt = ACC_WRITE_IN ? lane_ok : '0;
            cnt_nxt = ACC_WRITE_IN ? WR_LAST : RD_LAST;
            st_nxt = ST_ACC;
          end
        end
      end
      ST_ROW: begin
        if (cnt_r == '0) begin
          low_nxt[ADDR_MUX_W-1:0] = addr_r[ADDR_MUX_W-1:0];
          pin16_nxt = PIN_LOW;
          wr_n_nxt = !write_r;
          rd_n_nxt = write_r;
          dout_nxt = wdata_r;
          doe_nxt = write_r ? lane_ok : '0;
          cnt_nxt = write_r ? WR_LAST : RD_LAST;
          st_nxt = ST_ACC;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_ACC: begin
        wr_n_nxt = !write_r;
        rd_n_nxt = write_r;
        sel0_n_nxt = dyn_r ? PIN_HIGH : sel_level(SEL_ZERO, sel_r);
        doe_nxt = write_r ? lane_ok : '0;
        if (cnt_r == '0) begin
          if (!write_r) begin
            rdata_nxt = data_sync & lane_ok;
          end
          st_nxt = ST_END;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_END: begin
        // release selects and dynamic strobes
        if (dyn_r) begin
          pin16_nxt = PIN_HIGH;
          pin17_nxt = PIN_HIGH;
        end else begin
          if (SELECT_THREE_EN_IN) begin
            pin15_nxt = PIN_HIGH;
          end
          if (SELECT_TWO_EN_IN) begin
            pin16_nxt = PIN_HIGH;
          end
          if (SELECT_ONE_EN_IN) begin
            pin17_nxt = PIN_HIGH;
          end
        end
        done_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase

    if (st_nxt == ST_IDLE) begin
      doe_nxt = '0;
    end

    if (SW_RESET_IN) begin
      // soft reset keeps low lines only
      pin15_nxt = PIN_HIGH;
      pin16_nxt = PIN_HIGH;
      pin17_nxt = PIN_HIGH;
    end else if (IND_RESET_IN || STOP_IN) begin
      if (DYNAMIC_MODE_IN) begin
        // refresh keeps strobes low only in individual reset
        pin16_nxt = (IND_RESET_IN && REFRESH_EN_IN) ? PIN_LOW : PIN_HIGH;
        pin17_nxt = (IND_RESET_IN && REFRESH_EN_IN) ? PIN_LOW : PIN_HIGH;
      end else begin
        pin15_nxt = SELECT_THREE_EN_IN ? PIN_HIGH : pin15_r;
        pin16_nxt = SELECT_TWO_EN_IN ? PIN_HIGH : pin16_r;
        pin17_nxt = SELECT_ONE_EN_IN ? PIN_HIGH : pin17_r;
      end
    end
    if (in_reset) begin
      // abort access, selects and strobes high
      low_nxt = low_r;
      sel0_n_nxt = PIN_HIGH;
      wr_n_nxt = PIN_HIGH;
      rd_n_nxt = PIN_HIGH;
      doe_nxt = '0;
      done_nxt = 1'b0;
      st_nxt = ST_IDLE;
    end

    ready_nxt = (st_nxt == ST_IDLE) && !in_reset;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      sel_r <= SEL_ZERO;
      write_r <= 1'b0;
      dyn_r <= 1'b0;
      low_r <= '1;
      pin15_r <= PIN_HIGH;
      pin16_r <= PIN_HIGH;
      pin17_r <= PIN_HIGH;
      sel0_n_r <= PIN_HIGH;
      wr_n_r <= PIN_HIGH;
      rd_n_r <= PIN_HIGH;
      dout_r <= '0;
      doe_r <= '0;
      rdata_r <= '0;
      done_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      sel_r <= sel_nxt;
      write_r <= write_nxt;
      dyn_r <= dyn_nxt;
      low_r <= low_nxt;
      pin15_r <= pin15_nxt;
      pin16_r <= pin16_nxt;
      pin17_r <= pin17_nxt;
      sel0_n_r <= sel0_n_nxt;
      wr_n_r <= wr_n_nxt;
      rd_n_r <= rd_n_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign ACC_READY_OUT = ready_r;
  assign ACC_DONE_OUT = done_r;
  assign ACC_RDATA_OUT = rdata_r;
  assign LOW_ADDRESS_LINES_OUT = low_r;
  assign ADDRESS_BIT_FIFTEEN_OUT = pin15_r;
  assign ADDRESS_BIT_SIXTEEN_OUT = pin16_r;
  assign ADDRESS_BIT_SEVENTEEN_OUT = pin17_r;
  assign STATIC_SELECT_ZERO_N_OUT = sel0_n_r;
  assign WRITE_STROBE_N_OUT = wr_n_r;
  assign READ_STROBE_N_OUT = rd_n_r;
  assign MEMORY_DATA_BUS_OUT = dout_r;
  assign MEMORY_DATA_BUS_OE_OUT = doe_r;

endmodule
`default_nettype wire

// ### emp_pins_assertions.sv
// concurrent checks on the external memory pin sequencer
`timescale 1ns/1ps
`default_nettype none
module emp_pins_assertions
  import emp_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic SW_RESET_IN,
  input wire logic IND_RESET_IN,
  input wire logic DYNAMIC_MODE_IN,
  input wire logic REFRESH_EN_IN,
  input wire logic NARROW_BUS_IN,
  input wire logic ACC_READY_OUT,
  input wire logic [ADDR_LOW_W-1:0] LOW_ADDRESS_LINES_OUT,
  input wire logic ADDRESS_BIT_FIFTEEN_OUT,
  input wire logic ADDRESS_BIT_SIXTEEN_OUT,
  input wire logic ADDRESS_BIT_SEVENTEEN_OUT,
  input wire logic STATIC_SELECT_ZERO_N_OUT,
  input wire logic WRITE_STROBE_N_OUT,
  input wire logic READ_STROBE_N_OUT,
  input wire logic [DATA_W-1:0] MEMORY_DATA_BUS_OE_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  logic [5:0] pin_hi;
  logic [7:0] oe;
  assign pin_hi = {ADDRESS_BIT_FIFTEEN_OUT, ADDRESS_BIT_SIXTEEN_OUT, ADDRESS_BIT_SEVENTEEN_OUT,
    STATIC_SELECT_ZERO_N_OUT, WRITE_STROBE_N_OUT, READ_STROBE_N_OUT};
  assign oe = MEMORY_DATA_BUS_OE_OUT;
  // no disable here: the reset itself is the antecedent
  a_hw_reset_park:
    assert property (!RST_N_IN |-> pin_hi == 6'h3F && LOW_ADDRESS_LINES_OUT == 15'h7FFF && oe == 8'h00)
    else $error("pins not parked in reset");
  a_write_drives_bus:
    assert property (disable iff (!RST_N_IN) !WRITE_STROBE_N_OUT |-> READ_STROBE_N_OUT
      && oe == (NARROW_BUS_IN ? 8'h0F : 8'hFF)) else $error("bad drive during write");
  a_read_bus_free:
    assert property (disable iff (!RST_N_IN) !READ_STROBE_N_OUT |-> WRITE_STROBE_N_OUT && oe == 8'h00)
    else $error("bus driven during read");
  a_idle_bus_float:
    assert property (disable iff (!RST_N_IN) ACC_READY_OUT |-> oe == 8'h00)
    else $error("bus driven while idle");
  a_narrow_upper_float:
    assert property (disable iff (!RST_N_IN) NARROW_BUS_IN |-> oe[7:4] == 4'h0)
    else $error("upper lanes driven");
  a_soft_reset_park:
    assert property (disable iff (!RST_N_IN) SW_RESET_IN |=> pin_hi == 6'h3F && oe == 8'h00
      && $stable(LOW_ADDRESS_LINES_OUT)) else $error("soft reset levels wrong");
  a_ind_refresh_low:
    assert property (disable iff (!RST_N_IN) IND_RESET_IN && !SW_RESET_IN && DYNAMIC_MODE_IN
      && REFRESH_EN_IN |=> pin_hi[4:0] == 5'h07 && oe == 8'h00) else $error("refresh strobes wrong");
  a_row_before_col:
    assert property (disable iff (!RST_N_IN) DYNAMIC_MODE_IN && $fell(ADDRESS_BIT_SIXTEEN_OUT)
      |-> !ADDRESS_BIT_SEVENTEEN_OUT) else $error("column strobe before row");
endmodule
bind emp_pins emp_pins_assertions i_chk (.MCLK_IN, .RST_N_IN, .SW_RESET_IN, .IND_RESET_IN, .DYNAMIC_MODE_IN,
  .REFRESH_EN_IN, .NARROW_BUS_IN, .ACC_READY_OUT, .LOW_ADDRESS_LINES_OUT, .ADDRESS_BIT_FIFTEEN_OUT,
  .ADDRESS_BIT_SIXTEEN_OUT, .ADDRESS_BIT_SEVENTEEN_OUT, .STATIC_SELECT_ZERO_N_OUT, .WRITE_STROBE_N_OUT,
  .READ_STROBE_N_OUT, .MEMORY_DATA_BUS_OE_OUT);
`default_nettype wire

// ### emp_mem_model.sv
// behavioural byte memory standing on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model (
  input wire logic clk_in,
  input wire logic [14:0] addr_in,
  input wire logic write_n_in,
  input wire logic read_n_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] drive_out
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  always @(posedge clk_in) begin
    if (!write_n_in)
      mem[addr_in[7:0]] <= bus_in;
    last_r <= drive_out;
  end
  // no pull-ups: a released bus toggles so stale data never passes
  assign drive_out = !read_n_in ? mem[addr_in[7:0]] : ~last_r;
endmodule
`default_nettype wire

// ### tb_emp_pins.sv
// self-checking bench for the external memory pin sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_emp_pins;
  import emp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic sw = 1'b0, ind = 1'b0, stp = 1'b0, dyn = 1'b0, refr = 1'b0, nar = 1'b0, req = 1'b0, wr = 1'b0;
  logic [2:0] en = 3'h0;
  logic [1:0] sel = 2'h0;
  logic [21:0] addr = 22'h000000;
  logic [7:0] wd = 8'h00;
  logic rdy, done, p15, p16, p17, s0, wn, rn;
  logic [7:0] rd, dout, doe, dbus, mq;
  logic [14:0] lo;
  logic [31:0] rng = 32'h00009229;
  logic [7:0] mirror [256];
  logic [8:0] expq [$];
  int miscompares = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  assign dbus = (doe & dout) | (~doe & mq);
  emp_pins i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .SW_RESET_IN(sw), .IND_RESET_IN(ind), .STOP_IN(stp),
    .DYNAMIC_MODE_IN(dyn), .REFRESH_EN_IN(refr), .NARROW_BUS_IN(nar), .SELECT_THREE_EN_IN(en[2]),
    .SELECT_TWO_EN_IN(en[1]), .SELECT_ONE_EN_IN(en[0]), .ACC_REQ_IN(req), .ACC_WRITE_IN(wr),
    .ACC_SELECT_IN(sel), .ACC_ADDR_IN(addr), .ACC_WDATA_IN(wd), .ACC_READY_OUT(rdy), .ACC_DONE_OUT(done),
    .ACC_RDATA_OUT(rd), .LOW_ADDRESS_LINES_OUT(lo), .ADDRESS_BIT_FIFTEEN_OUT(p15),
    .ADDRESS_BIT_SIXTEEN_OUT(p16), .ADDRESS_BIT_SEVENTEEN_OUT(p17), .STATIC_SELECT_ZERO_N_OUT(s0),
    .WRITE_STROBE_N_OUT(wn), .READ_STROBE_N_OUT(rn), .MEMORY_DATA_BUS_IN(dbus),
    .MEMORY_DATA_BUS_OUT(dout), .MEMORY_DATA_BUS_OE_OUT(doe));
  emp_mem_model i_mem (.clk_in(clk), .addr_in(lo), .write_n_in(wn), .read_n_in(rn), .bus_in(dbus),
    .drive_out(mq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    if (n == 40)
      check("ready", 32'h0, 32'h1);
  endtask
  // request held until the edge that sees ready high
  task automatic take(input logic w, input logic [1:0] s, input logic [21:0] a);
    rng = xs(rng);
    req = 1'b1;
    wr = w;
    sel = s;
    addr = a;
    wd = rng[7:0];
    wait_ready();
    step(1);
    req = 1'b0;
  endtask
  task automatic acc(input logic w, input logic [1:0] s, input logic [21:0] a);
    int n;
    logic [7:0] drv;
    n = 0;
    drv = nar ? 8'h0F : 8'hFF;
    take(w, s, a);
    if (w)
      mirror[a[7:0]] = wd;
    expq.push_back({~w, nar ? {4'h0, mirror[a[7:0]][3:0]} : mirror[a[7:0]]});
    if (dyn)
      check("row", {p16, p17, lo[10:0]}, {2'h2, a[21:11]});
    while ((wn & rn) === 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    if (dyn)
      check("column", {p16, p17, s0, lo[10:0]}, {3'h1, a[10:0]});
    else
      check("static", {p15, p16, p17, s0, lo}, {en[2] ? (s != 2'h3) : a[15],
        en[1] ? (s != 2'h2) : a[16], en[0] ? (s != 2'h1) : a[17], s != 2'h0, a[14:0]});
    check("strobes", {wn, rn, doe, dout & doe}, {~w, w, w ? drv : 8'h00, w ? drv & wd : 8'h00});
    wait_ready();
  endtask
  always @(posedge clk) begin
    #1;
    if (done === 1'b1) begin
      if (expq.size() == 0)
        check("unexpected done", 32'h1, 32'h0);
      else if (expq[0][8])
        check("read data", rd, expq[0][7:0]);
      if (expq.size() > 0)
        void'(expq.pop_front());
    end
  end
  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [21:0] a;
    #1;
    rst_n = 1'b0;
    step(3);
    rst_n = 1'b1;
    // static, dynamic, then both again on the narrow bus
    for (int k = 0; k < 32; k++) begin
      dyn = k[3];
      nar = k[4];
      en = k[2:0];
      rng = xs(rng);
      a = {rng[21:8], k[7:0]};
      acc(1'b1, k[1:0], a);
      acc(1'b0, k[1:0], a);
    end
    nar = 1'b0;
    refr = 1'b1;
    take(1'b1, 2'h0, 22'h2AAAAA);
    ind = 1'b1;
    step(2);
    check("individual", {p16, p17, s0, wn, rn, doe}, {5'h07, 8'h00});
    ind = 1'b0;
    stp = 1'b1;
    step(2);
    check("stop", {p16, p17, s0, wn, rn, doe}, {5'h1F, 8'h00});
    stp = 1'b0;
    ind = 1'b1;
    refr = 1'b0;
    step(2);
    check("no refresh", {p16, p17, s0, wn, rn, doe}, {5'h1F, 8'h00});
    ind = 1'b0;
    dyn = 1'b0;
    take(1'b0, 2'h0, 22'h00ABCD);
    sw = 1'b1;
    step(2);
    check("soft", {p15, p16, p17, s0, wn, rn, lo}, {6'h3F, 15'h2BCD});
    sw = 1'b0;
    take(1'b1, 2'h1, 22'h012345);
    rst_n = 1'b0;
    step(1);
    check("hard", {p15, p16, p17, s0, wn, rn, lo, doe}, {6'h3F, 15'h7FFF, 8'h00});
    rst_n = 1'b1;
    acc(1'b1, 2'h0, 22'h000055);
    acc(1'b0, 2'h0, 22'h000055);
    step(10);
    close_out();
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
